// >>> hdl/flash_sector_access_control.sv
// sector access and protection controller around a byte-wide program array
// assumes requests are synchronous to MCLK and that the array is modelled here
`include "flash_access_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module flash_sector_access_control #(
  parameter int FLASH_SIZE = `DEFAULT_FLASH_SIZE
) (
  input  wire logic                     MCLK,
  input  wire logic                     RST_N,
  input  wire flash_access_pkg::prog_mode_t MODE,
  input  wire logic                     GUARD_WR,
  input  wire logic [7:0]               GUARD_DATA,
  input  wire logic                     REQ_VALID,
  input  wire flash_access_pkg::req_t   REQ,
  input  wire logic                     EXT_READ,
  output logic                          REQ_READY,
  output flash_access_pkg::rsp_t        RSP,
  output logic                          PROTECT_ON,
  output logic                          LVD_ENABLE,
  output logic                          GUARD_OPEN
);
  localparam int DEPTH  = (FLASH_SIZE > 65536) ? 65536 : FLASH_SIZE;
  localparam int ABITS  = $clog2(DEPTH);
  localparam logic [15:0] BASE = 16'(65536 - DEPTH);
  localparam int NSECT  = (FLASH_SIZE <= `SIZE_4K) ? 1 : (FLASH_SIZE <= `SIZE_8K) ? 2 : 3;

  logic rst_s1_reg;
  logic rst_s2_reg;
  logic rst_n;
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end
  assign rst_n = rst_s2_reg;

  logic [7:0] mem [DEPTH];
  logic [7:0] option_reg;
  logic [7:0] option_next;
  logic [1:0] guard_reg;
  logic [1:0] guard_next;
  flash_access_pkg::state_t state_reg;
  flash_access_pkg::state_t state_next;
  logic [ABITS-1:0] ptr_reg;
  logic [ABITS-1:0] ptr_next;
  logic [ABITS-1:0] lo_reg;
  logic [ABITS-1:0] lo_next;
  logic [ABITS-1:0] hi_reg;
  logic [ABITS-1:0] hi_next;
  logic             after_opt_reg;
  logic             after_opt_next;
  logic [7:0]       opt_pend_reg;
  logic [7:0]       opt_pend_next;
  flash_access_pkg::rsp_t rsp_reg;
  flash_access_pkg::rsp_t rsp_next;

  // sector index of an address: 0 top, 1 next, 2 the rest
  function automatic logic [1:0] sector_of(input logic [15:0] a);
    if (a >= `SECTOR0_BASE) return 2'd0;
    if (a >= `SECTOR1_BASE) return 2'd1;
    return 2'd2;
  endfunction

  logic        in_range;
  logic [1:0]  sect;
  logic        sect_ok;
  logic        may_alter;
  logic        alter_op;
  logic [ABITS-1:0] idx;
  logic        do_prog;

  assign in_range  = REQ.addr >= BASE;
  assign sect      = sector_of(REQ.addr);
  assign sect_ok   = in_range && (32'(sect) < NSECT);
  assign idx       = ABITS'(REQ.addr - BASE);
  assign alter_op  = REQ.op inside {flash_access_pkg::OP_PROG, flash_access_pkg::OP_SECT_ERASE,
                                    flash_access_pkg::OP_BULK_ERASE, flash_access_pkg::OP_OPT_WRITE};
  // tool/in-circuit: everything; in-application: never sector 0 nor bulk/option
  always_comb begin
    case (MODE)
      flash_access_pkg::MODE_TOOL, flash_access_pkg::MODE_ICP: may_alter = 1'b1;
      flash_access_pkg::MODE_IAP: may_alter = (REQ.op == flash_access_pkg::OP_PROG ||
                                               REQ.op == flash_access_pkg::OP_SECT_ERASE) &&
                                              sect != 2'd0;
      default: may_alter = 1'b0;
    endcase
  end

  assign REQ_READY  = (state_reg == flash_access_pkg::ST_IDLE);
  assign PROTECT_ON = option_reg[`OPT_PROTECT_BIT];
  assign LVD_ENABLE = !PROTECT_ON;
  assign GUARD_OPEN = (guard_reg == 2'd2);
  assign RSP        = rsp_reg;

  always_comb begin
    option_next    = option_reg;
    guard_next     = guard_reg;
    state_next     = state_reg;
    ptr_next       = ptr_reg;
    lo_next        = lo_reg;
    hi_next        = hi_reg;
    after_opt_next = after_opt_reg;
    opt_pend_next  = opt_pend_reg;
    rsp_next       = '0;
    do_prog        = 1'b0;
    if (GUARD_WR) begin
      if (guard_reg == 2'd0 && GUARD_DATA == `GUARD_KEY1) guard_next = 2'd1;
      else if (guard_reg == 2'd1 && GUARD_DATA == `GUARD_KEY2) guard_next = 2'd2;
      else guard_next = 2'd0;
    end
    case (state_reg)
      flash_access_pkg::ST_IDLE: begin
        if (REQ_VALID && REQ.op == flash_access_pkg::OP_READ) begin
          rsp_next.done = 1'b1;
          if (EXT_READ && PROTECT_ON) rsp_next.refused = 1'b1;
          else if (in_range) rsp_next.rdata = mem[idx];
          else rsp_next.rdata = `ERASED_BYTE;
        end else if (REQ_VALID && alter_op) begin
          guard_next = 2'd0;
          if (!GUARD_OPEN || !may_alter) begin
            rsp_next.done    = 1'b1;
            rsp_next.refused = 1'b1;
          end else begin
            case (REQ.op)
              flash_access_pkg::OP_PROG: begin
                rsp_next.done    = 1'b1;
                rsp_next.refused = !sect_ok;
                do_prog          = sect_ok;
              end
              flash_access_pkg::OP_SECT_ERASE: begin
                if (sect_ok) begin
                  lo_next    = (sect == 2'd0) ? ABITS'(`SECTOR0_BASE - BASE) :
                               (sect == 2'd1) ? ABITS'(`SECTOR1_BASE - BASE) : '0;
                  hi_next    = (sect == 2'd0) ? ABITS'(DEPTH - 1) :
                               (sect == 2'd1) ? ABITS'(`SECTOR0_BASE - BASE - 1) :
                               ABITS'(`SECTOR1_BASE - BASE - 1);
                  ptr_next   = lo_next;
                  state_next = flash_access_pkg::ST_ERASE;
                end else begin
                  rsp_next.done    = 1'b1;
                  rsp_next.refused = 1'b1;
                end
              end
              flash_access_pkg::OP_BULK_ERASE: begin
                lo_next    = '0;
                hi_next    = ABITS'(DEPTH - 1);
                ptr_next   = '0;
                state_next = flash_access_pkg::ST_ERASE;
              end
              default: begin
                if (PROTECT_ON && !REQ.data[`OPT_PROTECT_BIT]) begin
                  lo_next        = '0;
                  hi_next        = ABITS'(DEPTH - 1);
                  ptr_next       = '0;
                  after_opt_next = 1'b1;
                  opt_pend_next  = REQ.data;
                  state_next     = flash_access_pkg::ST_ERASE;
                end else begin
                  option_next   = REQ.data;
                  rsp_next.done = 1'b1;
                end
              end
            endcase
          end
        end
      end
      flash_access_pkg::ST_ERASE: begin
        ptr_next = ptr_reg + 1'b1;
        if (ptr_reg == hi_reg) state_next = flash_access_pkg::ST_DONE;
      end
      flash_access_pkg::ST_DONE: begin
        if (after_opt_reg) option_next = opt_pend_reg;
        after_opt_next = 1'b0;
        rsp_next.done  = 1'b1;
        state_next     = flash_access_pkg::ST_IDLE;
      end
      default: state_next = flash_access_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      option_reg    <= 8'h00;
      guard_reg     <= 2'd0;
      state_reg     <= flash_access_pkg::ST_IDLE;
      ptr_reg       <= '0;
      lo_reg        <= '0;
      hi_reg        <= '0;
      after_opt_reg <= 1'b0;
      opt_pend_reg  <= 8'h00;
      rsp_reg       <= '0;
    end else begin
      option_reg    <= option_next;
      guard_reg     <= guard_next;
      state_reg     <= state_next;
      ptr_reg       <= ptr_next;
      lo_reg        <= lo_next;
      hi_reg        <= hi_next;
      after_opt_reg <= after_opt_next;
      opt_pend_reg  <= opt_pend_next;
      rsp_reg       <= rsp_next;
    end
  end

  // array has no reset: contents are nonvolatile
  always_ff @(posedge MCLK) begin
    if (state_reg == flash_access_pkg::ST_ERASE) mem[ptr_reg] <= `ERASED_BYTE;
    else if (do_prog) mem[idx] <= mem[idx] & REQ.data;
  end

  property p_iap_s0_refused;
    @(posedge MCLK) disable iff (!rst_n)
    (REQ_VALID && REQ_READY && MODE == flash_access_pkg::MODE_IAP && alter_op && sect == 2'd0)
      |=> (RSP.done && RSP.refused && state_reg == flash_access_pkg::ST_IDLE);
  endproperty
  a_iap_s0_refused: assert property (p_iap_s0_refused) else $error("iap sector 0 alter accepted");

  property p_protected_read;
    @(posedge MCLK) disable iff (!rst_n)
    (REQ_VALID && REQ_READY && REQ.op == flash_access_pkg::OP_READ && EXT_READ && PROTECT_ON)
      |=> (RSP.refused && RSP.rdata == 8'h00);
  endproperty
  a_protected_read: assert property (p_protected_read) else $error("protected read leaked");

  property p_lvd;
    @(posedge MCLK) disable iff (!rst_n) PROTECT_ON |-> !LVD_ENABLE;
  endproperty
  a_lvd: assert property (p_lvd) else $error("lvd on under protection");

  property p_unguarded;
    @(posedge MCLK) disable iff (!rst_n)
    (REQ_VALID && REQ_READY && alter_op && !GUARD_OPEN) |=> (RSP.refused && state_reg == flash_access_pkg::ST_IDLE);
  endproperty
  a_unguarded: assert property (p_unguarded) else $error("unguarded alter accepted");

  property p_unprotect_erases;
    @(posedge MCLK) disable iff (!rst_n)
    (state_reg == flash_access_pkg::ST_ERASE && after_opt_reg) |-> (PROTECT_ON && lo_reg == '0);
  endproperty
  a_unprotect_erases: assert property (p_unprotect_erases) else $error("option cleared before erase");

  property p_opt_bit;
    @(posedge MCLK) disable iff (!rst_n)
    (state_reg == flash_access_pkg::ST_DONE && after_opt_reg) |=> (PROTECT_ON == $past(opt_pend_reg[`OPT_PROTECT_BIT]));
  endproperty
  a_opt_bit: assert property (p_opt_bit) else $error("option bit not applied");

  property p_erase_bounded;
    @(posedge MCLK) disable iff (!rst_n)
    (state_reg == flash_access_pkg::ST_ERASE) |-> (ptr_reg >= lo_reg && ptr_reg <= hi_reg);
  endproperty
  a_erase_bounded: assert property (p_erase_bounded) else $error("erase outside sector");

  property p_s0_range;
    @(posedge MCLK) disable iff (!rst_n)
    (REQ_VALID && REQ.addr >= `SECTOR0_BASE) |-> (sect == 2'd0);
  endproperty
  a_s0_range: assert property (p_s0_range) else $error("sector 0 decode wrong");
endmodule
`default_nettype wire

// >>> hdl/flash_access_cfg.svh
// constants for the sector access controller
// assumes a 16-bit address space with sectors stacked at the top
`ifndef FLASH_ACCESS_CFG_SVH
`define FLASH_ACCESS_CFG_SVH
`define SECTOR_SIZE_BYTES   4096
`define SECTOR0_BASE        16'hF000
`define SECTOR1_BASE        16'hE000
`define SIZE_4K             32'h0000_1000
`define SIZE_8K             32'h0000_2000
`define DEFAULT_FLASH_SIZE  32'h0000_F000
`define GUARD_KEY1          8'h56
`define GUARD_KEY2          8'hAE
`define ERASED_BYTE         8'hFF
`define OPT_PROTECT_BIT     0
`endif

// >>> hdl/flash_access_pkg.sv
// types for the sector access controller
// assumes the constants header is included alongside
`default_nettype none
package flash_access_pkg;
  typedef enum logic [1:0] {
    MODE_NONE = 2'b00,
    MODE_TOOL = 2'b01,
    MODE_ICP  = 2'b11,
    MODE_IAP  = 2'b10
  } prog_mode_t;

  typedef enum logic [2:0] {
    OP_IDLE      = 3'h0,
    OP_PROG      = 3'h1,
    OP_SECT_ERASE= 3'h2,
    OP_BULK_ERASE= 3'h3,
    OP_OPT_WRITE = 3'h4,
    OP_READ      = 3'h5
  } op_t;

  typedef struct packed {
    op_t         op;
    logic [15:0] addr;
    logic [7:0]  data;
  } req_t;

  typedef struct packed {
    logic        done;
    logic        refused;
    logic [7:0]  rdata;
  } rsp_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ERASE = 2'b01,
    ST_DONE  = 2'b11
  } state_t;
endpackage
`default_nettype wire

// >>> bench/prog_tool.sv
// programming tool model: guard keys, then one request, then wait for done
// assumes the controller takes a request on an edge with ready high
`include "flash_access_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module prog_tool (
  input  wire logic                    MCLK,
  input  wire logic                    REQ_READY,
  input  wire flash_access_pkg::rsp_t  RSP,
  output flash_access_pkg::prog_mode_t MODE,
  output logic                         GUARD_WR,
  output logic [7:0]                   GUARD_DATA,
  output logic                         REQ_VALID,
  output flash_access_pkg::req_t       REQ,
  output logic                         EXT_READ
);
  initial begin
    MODE = flash_access_pkg::MODE_NONE;
    GUARD_WR = 1'b0;
    GUARD_DATA = 8'h00;
    REQ_VALID = 1'b0;
    REQ = '0;
    EXT_READ = 1'b0;
  end
  task automatic key(input logic [7:0] k);
    @(posedge MCLK) #1;
    GUARD_WR = 1'b1;
    GUARD_DATA = k;
  endtask
  // mode is only ever changed here, off the clock edge
  task automatic set_mode(input flash_access_pkg::prog_mode_t m);
    MODE = m;
  endtask
  // both keys, then the strobe drops with no request behind it
  task automatic keys_only;
    key(`GUARD_KEY1);
    key(`GUARD_KEY2);
    @(posedge MCLK) #1;
    GUARD_WR = 1'b0;
  endtask
  // released lines show the inverse of their last value
  task automatic xfer(input flash_access_pkg::op_t o, input logic [15:0] a, input logic [7:0] d,
                      input logic ext, input logic keys, output flash_access_pkg::rsp_t r);
    int n;
    if (keys) begin
      key(`GUARD_KEY1);
      key(`GUARD_KEY2);
    end
    @(posedge MCLK) #1;
    GUARD_WR = 1'b0;
    GUARD_DATA = ~GUARD_DATA;
    REQ = '{o, a, d};
    EXT_READ = ext;
    REQ_VALID = 1'b1;
    for (n = 0; n < 20 && REQ_READY !== 1'b1; n++) @(posedge MCLK) #1;
    @(posedge MCLK) #1;
    REQ_VALID = 1'b0;
    REQ = flash_access_pkg::req_t'(~REQ);
    EXT_READ = ~ext;
    for (n = 0; n < 9000 && RSP.done !== 1'b1; n++) @(posedge MCLK) #1;
    r = RSP;
  endtask
endmodule
`default_nettype wire

// >>> bench/tb_top.sv
// bench top: controller with an 8K array and the tool model
// assumes sectors 0 and 1 only, so E000h-FFFFh is the whole array
`include "flash_access_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam flash_access_pkg::op_t PG = flash_access_pkg::OP_PROG;
  localparam flash_access_pkg::op_t SE = flash_access_pkg::OP_SECT_ERASE;
  localparam flash_access_pkg::op_t BE = flash_access_pkg::OP_BULK_ERASE;
  localparam flash_access_pkg::op_t OW = flash_access_pkg::OP_OPT_WRITE;
  logic                         MCLK = 1'b0;
  logic                         RST_N = 1'b0;
  flash_access_pkg::prog_mode_t MODE;
  logic                         GUARD_WR, REQ_VALID, EXT_READ, REQ_READY, PROTECT_ON, LVD_ENABLE, GUARD_OPEN;
  logic [7:0]                   GUARD_DATA;
  flash_access_pkg::req_t       REQ;
  flash_access_pkg::rsp_t       RSP, r;
  int                           err_count = 0;
  int                           num_checks = 0;
  int                           cyc = 0;
  int                           busy = 0;
  always #5 MCLK = ~MCLK;
  flash_sector_access_control #(.FLASH_SIZE(32'h0000_2000)) dut (.MCLK(MCLK), .RST_N(RST_N),
    .MODE(MODE), .GUARD_WR(GUARD_WR), .GUARD_DATA(GUARD_DATA), .REQ_VALID(REQ_VALID), .REQ(REQ),
    .EXT_READ(EXT_READ), .REQ_READY(REQ_READY), .RSP(RSP), .PROTECT_ON(PROTECT_ON),
    .LVD_ENABLE(LVD_ENABLE), .GUARD_OPEN(GUARD_OPEN));
  prog_tool tool (.MCLK(MCLK), .REQ_READY(REQ_READY), .RSP(RSP), .MODE(MODE), .GUARD_WR(GUARD_WR),
    .GUARD_DATA(GUARD_DATA), .REQ_VALID(REQ_VALID), .REQ(REQ), .EXT_READ(EXT_READ));
  task automatic chk_flag(string nm, logic [1:0] e, logic [1:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic chk_byte(string nm, logic [7:0] e, logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_count(string nm, logic [15:0] e, logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  // alter op with keys unless told otherwise; expects done and the refusal flag
  task automatic op(flash_access_pkg::op_t o, logic [15:0] a, logic [7:0] d, logic keys, logic ref_e);
    tool.xfer(o, a, d, 1'b0, keys, r);
    chk_flag("response", {1'b1, ref_e}, {r.done, r.refused});
  endtask
  task automatic rd(logic [15:0] a, logic [7:0] e);
    tool.xfer(flash_access_pkg::OP_READ, a, 8'h00, 1'b0, 1'b0, r);
    chk_byte("read data", e, r.rdata);
  endtask
  task automatic t_tool;
    tool.set_mode(flash_access_pkg::MODE_TOOL);
    op(BE, 16'hF000, 8'h00, 1'b1, 1'b0);
    rd(16'hE000, 8'hFF);
    op(PG, 16'hF000, 8'hA5, 1'b1, 1'b0);
    rd(16'hF000, 8'hA5);
    op(PG, 16'hF000, 8'h0F, 1'b1, 1'b0);
    rd(16'hF000, 8'h05);
    op(PG, 16'hE000, 8'h3C, 1'b1, 1'b0);
    rd(16'hE000, 8'h3C);
    $display("test tool done");
  endtask
  task automatic t_guard;
    int b0;
    tool.set_mode(flash_access_pkg::MODE_ICP);
    op(PG, 16'hF000, 8'h00, 1'b0, 1'b1);
    op(PG, 16'hDFFF, 8'h00, 1'b1, 1'b1);
    tool.set_mode(flash_access_pkg::MODE_NONE);
    op(PG, 16'hE000, 8'h00, 1'b1, 1'b1);
    tool.set_mode(flash_access_pkg::MODE_ICP);
    rd(16'hF000, 8'h05);
    rd(16'hE000, 8'h3C);
    b0 = busy;
    op(SE, 16'hE000, 8'h00, 1'b1, 1'b0);
    // one busy cycle per byte of the sector plus the closing cycle
    chk_count("erase busy cycles", 16'(`SECTOR_SIZE_BYTES + 1), 16'(busy - b0));
    rd(16'hE000, 8'hFF);
    rd(16'hF000, 8'h05);
    tool.keys_only();
    chk_flag("guard open", 2'b01, {1'b0, GUARD_OPEN});
    op(PG, 16'hE002, 8'h00, 1'b0, 1'b0);
    chk_flag("guard consumed", 2'b00, {1'b0, GUARD_OPEN});
    rd(16'hE002, 8'h00);
    $display("test guard and sector done");
  endtask
  task automatic t_iap;
    tool.set_mode(flash_access_pkg::MODE_IAP);
    op(PG, 16'hF000, 8'h00, 1'b1, 1'b1);
    op(SE, 16'hFFFF, 8'h00, 1'b1, 1'b1);
    op(BE, 16'hE000, 8'h00, 1'b1, 1'b1);
    op(PG, 16'hE001, 8'h5A, 1'b1, 1'b0);
    rd(16'hE001, 8'h5A);
    rd(16'hF000, 8'h05);
    $display("test iap done");
  endtask
  task automatic t_prot;
    tool.set_mode(flash_access_pkg::MODE_ICP);
    op(OW, 16'h0000, 8'h01, 1'b1, 1'b0);
    chk_flag("protect lvd", 2'b10, {PROTECT_ON, LVD_ENABLE});
    tool.xfer(flash_access_pkg::OP_READ, 16'hF000, 8'h00, 1'b1, 1'b0, r);
    chk_flag("ext read", 2'b11, {r.done, r.refused});
    chk_byte("ext rdata", 8'h00, r.rdata);
    rd(16'hE001, 8'h5A);
    op(OW, 16'h0000, 8'h00, 1'b1, 1'b0);
    chk_flag("protect lvd", 2'b01, {PROTECT_ON, LVD_ENABLE});
    rd(16'hF000, 8'hFF);
    rd(16'hE001, 8'hFF);
    $display("test protection done");
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  always @(posedge MCLK) begin
    cyc++;
    if (REQ_READY === 1'b0) busy++;
    if (cyc == 60000) begin
      err_count++;
      close_out();
    end
  end
  initial begin
    repeat (6) @(posedge MCLK);
    #1 RST_N = 1'b1;
    repeat (4) @(posedge MCLK);
    #1;
    chk_flag("reset outputs", 2'b01, {PROTECT_ON, LVD_ENABLE});
    t_tool();
    t_guard();
    t_iap();
    t_prot();
    close_out();
  end
endmodule
`default_nettype wire
